// ### pkg/irv_defs.vh
// constants shared by the interrupt and reset vectoring block
`ifndef IRV_DEFS_VH
`define IRV_DEFS_VH

// ==========================================================
// vector table
`define IRV_VEC_TOP        16'hFFFE
`define IRV_VEC_COUNT      32
`define IRV_VEC_W          5
`define IRV_V_RESET        5'h00
`define IRV_V_SWI          5'h01
`define IRV_V_LOWSUP       5'h03
`define IRV_V_TIMER_PWM_UNIT_ONE_CH0     5'h05
`define IRV_V_TIMER_PWM_UNIT_ONE_CH1     5'h06
`define IRV_V_TIMER_PWM_UNIT_ONE_OVF     5'h0B
`define IRV_V_TIMER_PWM_UNIT_TWO_CH0     5'h0C
`define IRV_V_TIMER_PWM_UNIT_TWO_CH1     5'h0D
`define IRV_V_TIMER_PWM_UNIT_TWO_OVF     5'h0E
`define IRV_V_SPI          5'h0F
`define IRV_V_SCI_ERR      5'h10
`define IRV_V_SCI_RX       5'h11
`define IRV_V_SCI_TX       5'h12
`define IRV_V_PORTA        5'h14
`define IRV_V_PORTB        5'h15
`define IRV_V_ADC          5'h17
`define IRV_V_IIC          5'h18
`define IRV_V_RTC          5'h19
`define IRV_V_MODULO_TIMER         5'h1A
`define IRV_V_ANALOG_COMPARE_UNIT         5'h1E

// ==========================================================
// cpu frame and pipeline
`define IRV_CCR_IBIT       3
`define IRV_CCR_RST        8'h08
`define IRV_FRAME_LAST     3'h4
`define IRV_FILL_LAST      3'h2
`define IRV_STEP_PCL       3'h0
`define IRV_STEP_PCH       3'h1
`define IRV_STEP_X         3'h2
`define IRV_STEP_A         3'h3
`define IRV_STEP_CCR       3'h4

// ==========================================================
// reset cause and debug force reset fields
`define IRV_CAUSE_BADADDR  3
`define IRV_CAUSE_LOWSUP   1
`define IRV_FRC_BIT        0
`define IRV_READ_ZERO      8'h00

`endif

// ### rtl/irv_prio_arb.v
// fixed priority arbiter: lowest numbered pending request wins
`timescale 1ns/1ps

module irv_prio_arb #(
	parameter N = 32,
	parameter W = 5
) (
	// requests
	input  wire [N-1:0] req_in,
	// winner
	output reg          valid_out,
	output reg  [W-1:0] index_out
);

	integer i;

	// ==========================================================
	// scan downward so the lowest index is the last one kept
	always @* begin
		valid_out = 1'b0;
		index_out = {W{1'b0}};
		for (i = N - 1; i >= 0; i = i - 1) begin
			if (req_in[i]) begin
				valid_out = 1'b1;
				index_out = i[W-1:0];
			end
		end
	end

endmodule

// ### rtl/irv_top.v
// interrupt and reset vectoring: stack frame sequencer, vector arbiter, reset cause and debug force reset
`timescale 1ns/1ps
`include "irv_defs.vh"

module irv_top (
	// clock and reset
	input  wire        clk_in,
	input  wire        rst_b_in,
	// cpu control
	input  wire        instr_boundary_in,
	input  wire        soft_irq_instr_in,
	input  wire        return_from_irq_instr_in,
	input  wire [15:0] cpu_pc_in,
	input  wire [7:0]  cpu_a_in,
	input  wire [7:0]  cpu_x_in,
	input  wire [7:0]  condition_code_reg_in,
	input  wire [15:0] stack_ptr_in,
	// memory port, read data valid in the cycle mem_re_out is high
	input  wire [7:0]  mem_rdata_in,
	// peripheral flags and enables
	input  wire        low_supply_warn_flag_in,
	input  wire        low_supply_warn_ie_in,
	input  wire [2:0]  timer_pwm_unit_one_flag_in,
	input  wire [2:0]  timer_pwm_unit_one_ie_in,
	input  wire [2:0]  timer_pwm_unit_two_flag_in,
	input  wire [2:0]  timer_pwm_unit_two_ie_in,
	input  wire        spi_xfer_done_flag_in,
	input  wire        spi_mode_fault_flag_in,
	input  wire        spi_main_ie_in,
	input  wire        spi_tx_empty_flag_in,
	input  wire        spi_tx_empty_ie_in,
	input  wire [3:0]  async_serial_unit_err_flag_in,
	input  wire [3:0]  async_serial_unit_err_ie_in,
	input  wire [3:0]  async_serial_unit_rx_flag_in,
	input  wire [3:0]  async_serial_unit_rx_ie_in,
	input  wire [1:0]  async_serial_unit_tx_flag_in,
	input  wire [1:0]  async_serial_unit_tx_ie_in,
	input  wire        porta_pin_irq_flag_in,
	input  wire        porta_pin_irq_ie_in,
	input  wire        portb_pin_irq_flag_in,
	input  wire        portb_pin_irq_ie_in,
	input  wire        conversion_done_flag_in,
	input  wire        conversion_done_ie_in,
	input  wire        iic_flag_in,
	input  wire        iic_ie_in,
	input  wire        rtc_flag_in,
	input  wire        rtc_ie_in,
	input  wire        modulo_timer_flag_in,
	input  wire        modulo_timer_ie_in,
	input  wire        analog_compare_unit_flag_in,
	input  wire        analog_compare_unit_ie_in,
	// reset sources
	input  wire [1:0]  watchdog_timeout_sel_in,
	input  wire        watchdog_counter_expired_in,
	input  wire        low_supply_trip_in,
	input  wire        low_supply_reset_en_in,
	input  wire        ext_reset_pin_b_in,
	input  wire        bad_addr_access_in,
	// force-reset register access
	input  wire        debug_force_reset_user_wr_in,
	input  wire        debug_force_reset_bdm_wr_in,
	input  wire [7:0]  debug_force_reset_wdata_in,
	// memory port
	output reg  [15:0] mem_addr_out,
	output reg  [7:0]  mem_wdata_out,
	output reg         mem_we_out,
	output reg         mem_re_out,
	// cpu results
	output reg  [15:0] cpu_pc_out,
	output reg  [7:0]  cpu_a_out,
	output reg  [7:0]  cpu_x_out,
	output reg  [7:0]  condition_code_reg_out,
	output reg  [15:0] stack_ptr_out,
	output reg  [23:0] fetch_queue_out,
	output reg         seq_done_out,
	output reg         seq_busy_out,
	// arbiter view
	output reg         irq_pending_out,
	output reg  [4:0]  irq_vector_out,
	// reset control and registers
	output reg         mcu_reset_out,
	output reg  [7:0]  reset_cause_out,
	output reg  [7:0]  debug_force_reset_out
);

	localparam ST_IDLE = 3'h0;
	localparam ST_PUSH = 3'h1;
	localparam ST_VEC  = 3'h2;
	localparam ST_FILL = 3'h3;
	localparam ST_POP  = 3'h4;

	reg  [2:0]  state;
	reg  [2:0]  step;
	reg  [31:0] req_vec;
	reg         pin_meta;
	reg         pin_sync;
	wire        arb_valid;
	wire [4:0]  arb_index;
	wire        mask_set;
	wire        bdm_force;
	wire        lowsup_reset;
	wire        wdog_reset;
	wire        reset_event;
	wire        entry_take;

	// ==========================================================
	// helpers

	// vector n sits two bytes below vector n-1, counting down from the top
	function [15:0] vec_addr;
		input [4:0] num;
		begin
			vec_addr = `IRV_VEC_TOP - {10'h000, num, 1'b0};
		end
	endfunction

	// byte pushed at a given step of the frame
	function [7:0] frame_byte;
		input [2:0]  stp;
		input [15:0] pc;
		input [7:0]  xr;
		input [7:0]  ar;
		input [7:0]  cc;
		begin
			case (stp)
				`IRV_STEP_PCL: frame_byte = pc[7:0];
				`IRV_STEP_PCH: frame_byte = pc[15:8];
				`IRV_STEP_X:   frame_byte = xr;
				`IRV_STEP_A:   frame_byte = ar;
				default:       frame_byte = cc;
			endcase
		end
	endfunction

	// ==========================================================
	// request map; slots not named here stay zero
	always @* begin
		req_vec = 32'h00000000;
		req_vec[`IRV_V_LOWSUP]   = low_supply_warn_flag_in & low_supply_warn_ie_in;
		req_vec[`IRV_V_TIMER_PWM_UNIT_ONE_CH0] = timer_pwm_unit_one_flag_in[0] & timer_pwm_unit_one_ie_in[0];
		req_vec[`IRV_V_TIMER_PWM_UNIT_ONE_CH1] = timer_pwm_unit_one_flag_in[1] & timer_pwm_unit_one_ie_in[1];
		req_vec[`IRV_V_TIMER_PWM_UNIT_ONE_OVF] = timer_pwm_unit_one_flag_in[2] & timer_pwm_unit_one_ie_in[2];
		req_vec[`IRV_V_TIMER_PWM_UNIT_TWO_CH0] = timer_pwm_unit_two_flag_in[0] & timer_pwm_unit_two_ie_in[0];
		req_vec[`IRV_V_TIMER_PWM_UNIT_TWO_CH1] = timer_pwm_unit_two_flag_in[1] & timer_pwm_unit_two_ie_in[1];
		req_vec[`IRV_V_TIMER_PWM_UNIT_TWO_OVF] = timer_pwm_unit_two_flag_in[2] & timer_pwm_unit_two_ie_in[2];
		req_vec[`IRV_V_SPI]      = ((spi_xfer_done_flag_in | spi_mode_fault_flag_in) & spi_main_ie_in)
		                         | (spi_tx_empty_flag_in & spi_tx_empty_ie_in);
		req_vec[`IRV_V_SCI_ERR]  = |(async_serial_unit_err_flag_in & async_serial_unit_err_ie_in);
		req_vec[`IRV_V_SCI_RX]   = |(async_serial_unit_rx_flag_in & async_serial_unit_rx_ie_in);
		req_vec[`IRV_V_SCI_TX]   = |(async_serial_unit_tx_flag_in & async_serial_unit_tx_ie_in);
		req_vec[`IRV_V_PORTA]    = porta_pin_irq_flag_in & porta_pin_irq_ie_in;
		req_vec[`IRV_V_PORTB]    = portb_pin_irq_flag_in & portb_pin_irq_ie_in;
		req_vec[`IRV_V_ADC]      = conversion_done_flag_in & conversion_done_ie_in;
		req_vec[`IRV_V_IIC]      = iic_flag_in & iic_ie_in;
		req_vec[`IRV_V_RTC]      = rtc_flag_in & rtc_ie_in;
		req_vec[`IRV_V_MODULO_TIMER]     = modulo_timer_flag_in & modulo_timer_ie_in;
		req_vec[`IRV_V_ANALOG_COMPARE_UNIT]     = analog_compare_unit_flag_in & analog_compare_unit_ie_in;
	end

	// lowest numbered pending request wins
	irv_prio_arb #(
		.N (`IRV_VEC_COUNT),
		.W (`IRV_VEC_W)
	) u_arb (
		.req_in    (req_vec),
		.valid_out (arb_valid),
		.index_out (arb_index)
	);

	// ==========================================================
	// reset sources, all vectored through slot 0
	assign mask_set     = condition_code_reg_in[`IRV_CCR_IBIT];
	assign bdm_force    = debug_force_reset_bdm_wr_in & debug_force_reset_wdata_in[`IRV_FRC_BIT];
	assign lowsup_reset = low_supply_trip_in & low_supply_reset_en_in;
	assign wdog_reset   = watchdog_counter_expired_in & (|watchdog_timeout_sel_in);
	assign reset_event  = wdog_reset | lowsup_reset | ~pin_sync | bad_addr_access_in | bdm_force;

	// external reset pin comes from outside the clock domain
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
		end else begin
			pin_meta <= ext_reset_pin_b_in;
			pin_sync <= pin_meta;
		end
	end

	// ==========================================================
	// reset cause and force-reset register; rst_b_in acts as power-on
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			reset_cause_out       <= `IRV_READ_ZERO;
			reset_cause_out[`IRV_CAUSE_LOWSUP] <= 1'b1;
			debug_force_reset_out <= `IRV_READ_ZERO;
			mcu_reset_out         <= 1'b0;
		end else begin
			mcu_reset_out         <= reset_event;
			debug_force_reset_out <= `IRV_READ_ZERO;
			// user writes never reach the force bit, only the background path does
			if (reset_event) begin
				reset_cause_out <= `IRV_READ_ZERO;
				reset_cause_out[`IRV_CAUSE_BADADDR] <= bad_addr_access_in;
				reset_cause_out[`IRV_CAUSE_LOWSUP]  <= lowsup_reset;
			end
		end
	end

	// ==========================================================
	// arbiter view for the cpu: only unmasked requests count
	// the vector is frozen while a sequence runs so the fetch uses the one taken
	assign entry_take = (state == ST_IDLE) & ~reset_event
	                  & (soft_irq_instr_in | (instr_boundary_in & arb_valid & ~mask_set));

	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			irq_pending_out <= 1'b0;
			irq_vector_out  <= `IRV_V_RESET;
		end else begin
			irq_pending_out <= arb_valid & ~mask_set;
			if (entry_take) begin
				irq_vector_out <= soft_irq_instr_in ? `IRV_V_SWI : arb_index;
			end else if (!seq_busy_out) begin
				irq_vector_out <= arb_index;
			end
		end
	end

	// ==========================================================
	// frame sequencer: one memory byte per cycle, reset preempts everything
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			state                  <= ST_IDLE;
			step                   <= 3'h0;
			mem_addr_out           <= 16'h0000;
			mem_wdata_out          <= 8'h00;
			mem_we_out             <= 1'b0;
			mem_re_out             <= 1'b0;
			cpu_pc_out             <= 16'h0000;
			cpu_a_out              <= 8'h00;
			cpu_x_out              <= 8'h00;
			condition_code_reg_out <= `IRV_CCR_RST;
			stack_ptr_out          <= 16'h0000;
			fetch_queue_out        <= 24'h000000;
			seq_done_out           <= 1'b0;
			seq_busy_out           <= 1'b0;
		end else begin
			seq_done_out <= 1'b0;
			if (reset_event) begin
				// no frame on reset: mask interrupts and fetch vector 0 directly
				state        <= ST_VEC;
				step         <= 3'h0;
				mem_we_out   <= 1'b0;
				mem_re_out   <= 1'b1;
				mem_addr_out <= vec_addr(`IRV_V_RESET);
				condition_code_reg_out <= `IRV_CCR_RST;
				seq_busy_out <= 1'b1;
			end else begin
				case (state)
					ST_IDLE: begin
						if (soft_irq_instr_in || (instr_boundary_in && arb_valid && !mask_set)) begin
							// latch the resume address the cpu hands over
							cpu_pc_out             <= cpu_pc_in;
							cpu_a_out              <= cpu_a_in;
							cpu_x_out              <= cpu_x_in;
							condition_code_reg_out <= condition_code_reg_in;
							mem_addr_out           <= stack_ptr_in;
							mem_wdata_out          <= cpu_pc_in[7:0];
							mem_we_out             <= 1'b1;
							step                   <= `IRV_STEP_PCL;
							state                  <= ST_PUSH;
							seq_busy_out           <= 1'b1;
						end else if (return_from_irq_instr_in) begin
							mem_addr_out <= stack_ptr_in + 16'h0001;
							mem_re_out   <= 1'b1;
							step         <= `IRV_STEP_CCR;
							state        <= ST_POP;
							seq_busy_out <= 1'b1;
						end
					end
					ST_PUSH: begin
						if (step == `IRV_FRAME_LAST) begin
							mem_we_out    <= 1'b0;
							stack_ptr_out <= mem_addr_out - 16'h0001;
							condition_code_reg_out[`IRV_CCR_IBIT] <= 1'b1;
							mem_re_out    <= 1'b1;
							mem_addr_out  <= vec_addr(irq_vector_out);
							step          <= 3'h0;
							state         <= ST_VEC;
						end else begin
							mem_addr_out  <= mem_addr_out - 16'h0001;
							mem_wdata_out <= frame_byte(step + 3'h1, cpu_pc_out, cpu_x_out, cpu_a_out,
							                            condition_code_reg_out);
							step          <= step + 3'h1;
						end
					end
					ST_VEC: begin
						// high byte sits at the lower address
						if (step == 3'h0) begin
							cpu_pc_out[15:8] <= mem_rdata_in;
							mem_addr_out     <= mem_addr_out + 16'h0001;
							step             <= 3'h1;
						end else begin
							cpu_pc_out[7:0] <= mem_rdata_in;
							mem_addr_out    <= {cpu_pc_out[15:8], mem_rdata_in};
							step            <= 3'h0;
							state           <= ST_FILL;
						end
					end
					ST_POP: begin
						// pop order runs opposite to push order
						case (step)
							`IRV_STEP_CCR: condition_code_reg_out <= mem_rdata_in;
							`IRV_STEP_A:   cpu_a_out <= mem_rdata_in;
							`IRV_STEP_X:   cpu_x_out <= mem_rdata_in;
							`IRV_STEP_PCH: cpu_pc_out[15:8] <= mem_rdata_in;
							default:       cpu_pc_out[7:0] <= mem_rdata_in;
						endcase
						if (step == `IRV_STEP_PCL) begin
							stack_ptr_out <= mem_addr_out;
							mem_addr_out  <= {cpu_pc_out[15:8], mem_rdata_in};
							state         <= ST_FILL;
						end else begin
							mem_addr_out <= mem_addr_out + 16'h0001;
							step         <= step - 3'h1;
						end
					end
					ST_FILL: begin
						// three bytes into the queue, oldest in the top byte
						fetch_queue_out <= {fetch_queue_out[15:0], mem_rdata_in};
						if (step == `IRV_FILL_LAST) begin
							mem_re_out   <= 1'b0;
							seq_done_out <= 1'b1;
							seq_busy_out <= 1'b0;
							step         <= 3'h0;
							state        <= ST_IDLE;
						end else begin
							mem_addr_out <= mem_addr_out + 16'h0001;
							step         <= step + 3'h1;
						end
					end
					default: begin
						state        <= ST_IDLE;
						mem_we_out   <= 1'b0;
						mem_re_out   <= 1'b0;
						seq_busy_out <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule

// ### verif/irv_mem_model.sv
// memory model on the far side of the block: stack ram, program bytes and the vector table
`timescale 1ns/1ps

module irv_mem_model (
	// memory port
	input  wire        clk_in,
	input  wire [15:0] mem_addr_in,
	input  wire [7:0]  mem_wdata_in,
	input  wire        mem_we_in,
	input  wire        mem_re_in,
	output wire [7:0]  mem_rdata_out
);
	logic [7:0] mem [0:65535];
	logic [7:0] last;
	int i;
	// ==========================================================
	// contents: program bytes everywhere, vector n holds 16'h8020 plus n in its high byte
	initial begin
		last = 8'h00;
		for (i = 0; i < 65536; i++) begin
			mem[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
		end
		for (i = 0; i < 32; i++) begin
			mem[16'hFFFE - 2 * i] = 8'h80 + i[7:0];
			mem[16'hFFFF - 2 * i] = 8'h20;
		end
	end
	// write port and last read value
	always @(posedge clk_in) begin
		if (mem_we_in) begin
			mem[mem_addr_in] <= mem_wdata_in;
		end
		if (mem_re_in) begin
			last <= mem[mem_addr_in];
		end
	end
	// unread cycles show the inverse so a stale byte can never pass as valid
	assign mem_rdata_out = mem_re_in ? mem[mem_addr_in] : ~last;
endmodule

// ### verif/irv_top_sva.sv
// assertion checker for the interrupt and reset vectoring block
`timescale 1ns/1ps

module irv_top_sva (
	// clock and reset
	input wire        clk_in,
	input wire        rst_b_in,
	// watched signals
	input wire [15:0] cpu_pc_in,
	input wire        low_supply_warn_flag_in,
	input wire        low_supply_warn_ie_in,
	input wire        debug_force_reset_bdm_wr_in,
	input wire [7:0]  debug_force_reset_wdata_in,
	input wire [15:0] mem_addr_out,
	input wire [7:0]  mem_wdata_out,
	input wire        mem_we_out,
	input wire        mem_re_out,
	input wire [15:0] stack_ptr_out,
	input wire        seq_done_out,
	input wire        seq_busy_out,
	input wire        irq_pending_out,
	input wire [4:0]  irq_vector_out,
	input wire        mcu_reset_out,
	input wire [7:0]  reset_cause_out,
	input wire [7:0]  debug_force_reset_out
);
	// slots with no source behind them
	localparam logic [31:0] EMPTY = 32'hB8480794;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// ==========================================================
	// stack frame
	a_push_pc_first: assert property ($rose(mem_we_out) |-> mem_wdata_out == cpu_pc_in[7:0] ##1
		mem_wdata_out == cpu_pc_in[15:8]) else $error("stacked pc bytes wrong");
	a_push_five_bytes: assert property ($rose(mem_we_out) |-> mem_we_out [*5] ##1 !mem_we_out)
		else $error("frame length wrong");
	a_stack_grows_down: assert property (mem_we_out && $past(mem_we_out) |->
		mem_addr_out == $past(mem_addr_out) - 16'h1) else $error("stack address not descending");
	a_sp_next_free: assert property ($fell(mem_we_out) && mem_re_out && $past(mem_we_out, 5) |->
		stack_ptr_out == $past(mem_addr_out) - 16'h1) else $error("stack pointer after entry wrong");
	a_vector_pair: assert property ($fell(mem_we_out) && mem_re_out |-> mem_addr_out[15:6] == 10'h3FF &&
		!mem_addr_out[0] ##1 mem_addr_out == $past(mem_addr_out) + 16'h1) else $error("vector fetch wrong");
	a_fill_three: assert property (seq_done_out |-> !mem_re_out && $past(mem_re_out) && $past(mem_re_out, 2) &&
		$past(mem_re_out, 3) && $past(mem_addr_out) == $past(mem_addr_out, 2) + 16'h1 &&
		$past(mem_addr_out, 2) == $past(mem_addr_out, 3) + 16'h1) else $error("pipeline fill wrong");
	// ==========================================================
	// arbiter
	a_no_empty_slot: assert property (irq_pending_out |-> !EMPTY[irq_vector_out])
		else $error("unassigned vector presented");
	a_warn_wins: assert property ($past(low_supply_warn_flag_in && low_supply_warn_ie_in) && irq_pending_out &&
		!seq_busy_out && !$past(seq_busy_out) |-> irq_vector_out == 5'h03) else $error("warning not lowest");
	// ==========================================================
	// reset control and registers
	a_bdm_forces: assert property (debug_force_reset_bdm_wr_in && debug_force_reset_wdata_in[0] |=>
		mcu_reset_out) else $error("debug write did not reset");
	a_force_reads_zero: assert property (debug_force_reset_out == 8'h00)
		else $error("force reset register not zero");
	a_cause_clean: assert property (reset_cause_out[7:4] == 4'h0 && !reset_cause_out[2] &&
		!reset_cause_out[0]) else $error("reserved cause bits set");
	c_entry: cover property ($fell(mem_we_out) ##[1:6] seq_done_out);
	c_reset: cover property (mcu_reset_out ##[1:8] seq_done_out);
	c_pending: cover property (irq_pending_out && irq_vector_out == 5'h1E);
endmodule

bind irv_top irv_top_sva u_irv_top_sva (.clk_in(clk_in), .rst_b_in(rst_b_in), .cpu_pc_in(cpu_pc_in),
	.low_supply_warn_flag_in(low_supply_warn_flag_in), .low_supply_warn_ie_in(low_supply_warn_ie_in),
	.debug_force_reset_bdm_wr_in(debug_force_reset_bdm_wr_in),
	.debug_force_reset_wdata_in(debug_force_reset_wdata_in), .mem_addr_out(mem_addr_out),
	.mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out), .mem_re_out(mem_re_out),
	.stack_ptr_out(stack_ptr_out), .seq_done_out(seq_done_out), .seq_busy_out(seq_busy_out),
	.irq_pending_out(irq_pending_out), .irq_vector_out(irq_vector_out), .mcu_reset_out(mcu_reset_out),
	.reset_cause_out(reset_cause_out), .debug_force_reset_out(debug_force_reset_out));

// ### verif/tb_top.sv
// self-checking testbench for the interrupt and reset vectoring block
`timescale 1ns/1ps

module tb_top;
	localparam logic [31:0] MAP = 32'h47B7F868;
	logic        clk_in, rst_b_in, bnd, soft_irq_instr, return_from_irq_instr, trip, tren, pinb, bad, uwr, bwr, wexp, seen, gotd;
	logic [15:0] pc, sp;
	logic [7:0]  a, x, cc, wd;
	logic [31:0] fl, en, seed, r, r2;
	logic [1:0]  sb, wsel;
	wire  [15:0] maddr, pc_o, sp_o;
	wire  [7:0]  mwd, rd, a_o, x_o, cc_o, cause, frc;
	wire  [23:0] fq;
	wire  [4:0]  vec;
	wire         mwe, mre, done, busy, pend, mrst;
	int          fail_count, num_checks, cyc, k;
	// ==========================================================
	// design and memory
	irv_top u_irv_top (.clk_in(clk_in), .rst_b_in(rst_b_in), .instr_boundary_in(bnd), .soft_irq_instr_in(soft_irq_instr),
		.return_from_irq_instr_in(return_from_irq_instr), .cpu_pc_in(pc), .cpu_a_in(a), .cpu_x_in(x), .condition_code_reg_in(cc),
		.stack_ptr_in(sp), .mem_rdata_in(rd), .low_supply_warn_flag_in(fl[3]), .low_supply_warn_ie_in(en[3]),
		.timer_pwm_unit_one_flag_in({fl[11], fl[6:5]}), .timer_pwm_unit_one_ie_in({en[11], en[6:5]}),
		.timer_pwm_unit_two_flag_in(fl[14:12]), .timer_pwm_unit_two_ie_in(en[14:12]),
		.spi_xfer_done_flag_in(fl[15] && sb == 2'h0), .spi_mode_fault_flag_in(fl[15] && sb == 2'h1),
		.spi_main_ie_in(en[15]), .spi_tx_empty_flag_in(fl[15] && sb[1]), .spi_tx_empty_ie_in(en[15]),
		.async_serial_unit_err_flag_in({4{fl[16]}} & (4'h1 << sb)), .async_serial_unit_err_ie_in({4{en[16]}}),
		.async_serial_unit_rx_flag_in({4{fl[17]}} & (4'h1 << sb)), .async_serial_unit_rx_ie_in({4{en[17]}}),
		.async_serial_unit_tx_flag_in({2{fl[18]}} & (2'h1 << sb[0])), .async_serial_unit_tx_ie_in({2{en[18]}}),
		.porta_pin_irq_flag_in(fl[20]), .porta_pin_irq_ie_in(en[20]), .portb_pin_irq_flag_in(fl[21]),
		.portb_pin_irq_ie_in(en[21]), .conversion_done_flag_in(fl[23]), .conversion_done_ie_in(en[23]),
		.iic_flag_in(fl[24]), .iic_ie_in(en[24]), .rtc_flag_in(fl[25]), .rtc_ie_in(en[25]),
		.modulo_timer_flag_in(fl[26]), .modulo_timer_ie_in(en[26]), .analog_compare_unit_flag_in(fl[30]),
		.analog_compare_unit_ie_in(en[30]), .watchdog_timeout_sel_in(wsel), .watchdog_counter_expired_in(wexp),
		.low_supply_trip_in(trip), .low_supply_reset_en_in(tren), .ext_reset_pin_b_in(pinb),
		.bad_addr_access_in(bad), .debug_force_reset_user_wr_in(uwr), .debug_force_reset_bdm_wr_in(bwr),
		.debug_force_reset_wdata_in(wd), .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_we_out(mwe),
		.mem_re_out(mre), .cpu_pc_out(pc_o), .cpu_a_out(a_o), .cpu_x_out(x_o), .condition_code_reg_out(cc_o),
		.stack_ptr_out(sp_o), .fetch_queue_out(fq), .seq_done_out(done), .seq_busy_out(busy),
		.irq_pending_out(pend), .irq_vector_out(vec), .mcu_reset_out(mrst), .reset_cause_out(cause),
		.debug_force_reset_out(frc));
	irv_mem_model u_irv_mem_model (.clk_in(clk_in), .mem_addr_in(maddr), .mem_wdata_in(mwd), .mem_we_in(mwe),
		.mem_re_in(mre), .mem_rdata_out(rd));
	// ==========================================================
	// clock and hang guard, ceiling well above the roughly six hundred cycles needed
	always #2.5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test;
		end
	end
	// ==========================================================
	// helpers
	function [31:0] rnd;
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		rnd = seed;
	endfunction
	function [7:0] prog(input [15:0] q);
		prog = q[7:0] ^ q[15:8] ^ 8'h5A;
	endfunction
	function [23:0] fill(input [15:0] p);
		fill = {prog(p), prog(p + 16'h1), prog(p + 16'h2)};
	endfunction
	function [4:0] lowest(input [31:0] m);
		lowest = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (m[i]) lowest = i[4:0];
		end
	endfunction
	task tick;
		@(posedge clk_in);
		#1;
	endtask
	task chk(input [23:0] got, input [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait for the end of a sequence
	task wait_done;
		int n;
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			tick;
			n++;
		end
		chk(n < 40, 1'b1);
	endtask
	// one entry with random cpu state; vector 1 goes in with the mask set
	task do_entry(input [4:0] v);
		r = rnd();
		r2 = rnd();
		a = r[7:0];
		x = r[15:8];
		cc = {r[23:20], v == 5'h1, r[18:16]};
		sb = r[25:24];
		pc = {3'b001, r2[12:0]};
		sp = {10'h006, r2[18:13]};
		fl = (v > 5'h1) ? 32'h1 << v : 32'h0;
		tick;
		tick;
		if (v > 5'h1) chk(vec, v);
		if (v == 5'h1) soft_irq_instr = 1'b1;
		else bnd = 1'b1;
		tick;
		soft_irq_instr = 1'b0;
		bnd = 1'b0;
		wait_done;
		fl = 32'h0;
		chk(u_irv_mem_model.mem[sp], pc[7:0]);
		chk(u_irv_mem_model.mem[sp - 16'h1], pc[15:8]);
		chk(u_irv_mem_model.mem[sp - 16'h2], x);
		chk(u_irv_mem_model.mem[sp - 16'h3], a);
		chk(u_irv_mem_model.mem[sp - 16'h4], cc);
		chk(sp_o, sp - 16'h5);
		chk(cc_o[3], 1'b1);
		chk(pc_o, {8'h80 + {3'h0, v}, 8'h20});
		chk(fq, fill({8'h80 + {3'h0, v}, 8'h20}));
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{clk_in, rst_b_in, bnd, soft_irq_instr, return_from_irq_instr, trip, tren, bad, uwr, bwr, wexp, sb, wsel} = '0;
		{pc, sp, a, x, cc, wd, fl, cyc, fail_count, num_checks} = '0;
		pinb = 1'b1;
		en = 32'hFFFFFFFF;
		seed = 32'h5394945b;
		repeat (6) @(posedge clk_in);
		#1;
		rst_b_in = 1'b1;
		tick;
		chk(cc_o, 8'h08);
		chk(cause, 8'h02);
		chk(frc, 8'h00);
		$display("test reset values done");
		for (k = 1; k < 32; k++) begin
			if (MAP[k] || k == 1) begin
				do_entry(k[4:0]);
				sp = sp - 16'h5;
				return_from_irq_instr = 1'b1;
				tick;
				return_from_irq_instr = 1'b0;
				wait_done;
				chk(pc_o, pc);
				chk({a_o, x_o, cc_o}, {a, x, cc});
				chk(sp_o, sp + 16'h5);
				chk(fq, fill(pc));
			end
		end
		$display("test entry and return done");
		// local enable off, then global mask set: neither may be taken
		cc = 8'h00;
		fl = 32'h20;
		en = 32'h0;
		bnd = 1'b1;
		repeat (3) tick;
		chk(busy, 1'b0);
		chk(pend, 1'b0);
		en = 32'hFFFFFFFF;
		cc = 8'h08;
		repeat (3) tick;
		chk(busy, 1'b0);
		chk(pend, 1'b0);
		bnd = 1'b0;
		cc = 8'h00;
		$display("test masking done");
		// every source at once, then random mixes of pending flags
		fl = MAP;
		for (k = 0; k < 24; k++) begin
			tick;
			tick;
			chk(vec, lowest(fl));
			chk(pend, 1'b1);
			r = rnd();
			fl = (k == 0) ? 32'h40000000 : (r & MAP) | 32'h40000000;
			sb = r[1:0];
		end
		fl = 32'h0;
		$display("test priority done");
		// reset sources: user write, debug write, bad address, trip, watchdog, pin, trip not enabled
		for (k = 0; k < 7; k++) begin
			r = rnd();
			wd = r[7:0] | 8'h01;
			uwr = k == 0;
			bwr = k == 1;
			bad = k == 2;
			trip = k == 3 || k == 6;
			tren = k == 3;
			wsel = (k == 4) ? 2'h1 : 2'h0;
			wexp = k == 4;
			pinb = k != 5;
			tick;
			{uwr, bwr, bad, trip, tren, wexp, wsel} = '0;
			pinb = 1'b1;
			{seen, gotd} = 2'b00;
			repeat (14) begin
				if (mrst === 1'b1) seen = 1'b1;
				if (done === 1'b1) gotd = seen;
				tick;
			end
			chk(seen, k != 0 && k != 6);
			if (seen) begin
				chk(gotd, 1'b1);
				chk(pc_o, 16'h8020);
				chk(cc_o, 8'h08);
				chk(cause, (k == 2) ? 8'h08 : (k == 3) ? 8'h02 : 8'h00);
			end
		end
		$display("test reset sources done");
		end_of_test;
	end
	// ==========================================================
	// verdict
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
endmodule
